// File: design/pcg_pkg.sv
/*
 * Package for the programmable CRC generator: register map, field positions,
 * reset values, FIFO sizing, alias offsets and the APB request carrier.
 * Assumes a 32-bit APB slave with word-aligned byte addresses.
 */
package pcg_pkg;

	localparam int unsigned ADDR_W = 12;

	localparam logic [11:0] OFS_CONTROL  = 12'hA00;
	localparam logic [11:0] OFS_POLY     = 12'hA10;
	localparam logic [11:0] OFS_DATA_IN  = 12'hA20;
	localparam logic [11:0] OFS_RESULT   = 12'hA30;
	localparam logic [11:0] OFS_IRQ_STAT = 12'hA40;
	localparam logic [11:0] OFS_IRQ_MASK = 12'hA50;

	localparam logic [3:0] ALIAS_PLAIN = 4'h0;
	localparam logic [3:0] ALIAS_CLR   = 4'h4;
	localparam logic [3:0] ALIAS_SET   = 4'h8;
	localparam logic [3:0] ALIAS_INV   = 4'hC;

	localparam int unsigned F_WIDTH_LO = 24;
	localparam int unsigned F_PLEN_LO  = 16;
	localparam int unsigned F_ENABLE   = 15;
	localparam int unsigned F_IDLE     = 13;
	localparam int unsigned F_COUNT_LO = 8;
	localparam int unsigned F_FULL     = 7;
	localparam int unsigned F_EMPTY    = 6;
	localparam int unsigned F_ISEL     = 5;
	localparam int unsigned F_RUN      = 4;
	localparam int unsigned F_LSB      = 3;
	localparam int unsigned F_VARIANT  = 2;

	// Software-writable bits of the control register
	localparam logic [31:0] CTRL_WMASK = 32'h1F1FA03C;
	localparam logic [31:0] POLY_WMASK = 32'hFFFFFFFE;
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
	localparam logic [31:0] POLY_RESET = 32'h00000000;
	localparam logic [31:0] RES_RESET  = 32'h00000000;

	localparam logic [4:0] CAP_BYTE  = 5'h10;
	localparam logic [4:0] CAP_HALF  = 5'h08;
	localparam logic [4:0] CAP_WORD  = 5'h04;
	localparam logic [4:0] LIM_BYTE  = 5'h07;
	localparam logic [4:0] LIM_HALF  = 5'h0F;

	// Interrupt status bits: 0 FIFO emptied, 1 shift complete
	localparam int unsigned IRQ_BITS = 2;
	localparam int unsigned IRQ_EMPTIED = 0;
	localparam int unsigned IRQ_DONE    = 1;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              write;
		logic [31:0]       wdata;
	} pcg_req_s;

	typedef enum logic [1:0] {
		PCG_IDLE,
		PCG_LOAD,
		PCG_SHIFT
	} pcg_state_e;

endpackage

// File: design/pcg_crc.sv
/*
 * Programmable CRC generator with APB register access, data FIFO, serial
 * shifter and one level interrupt. Assumes a single clock, synchronous
 * inputs, and sys_idle high while the system is in idle mode.
 */
// Chosen here: register access over APB.
// Operation
// [RL1] Word width comes from a five-bit field holding width minus one.
// [RL2] Polynomial length comes from a five-bit field holding length minus one.
// [RL3] Nothing operates unless the module enable bit is set.
// [RL4] With idle halt set, operation pauses while the system idles.
// [RL5] Read-only valid word count; capacity 16, 8 or 4 by width.
// [RL6] Full flag is one exactly when the FIFO holds its capacity.
// [RL7] Empty flag is one with no words; it resets to one.
// [RL8] Select one: interrupt when the FIFO becomes empty.
// [RL9] Select zero: interrupt when empty and the last word shifted out.
// [RL10] Run bit starts draining; clearing aborts shifting; zero keeps shifter off.
// [RL11] LSB-first select shifts each word least significant bit first.
// [RL12] Otherwise each word shifts most significant bit first.
// [RL13] Algorithm variant bit selects alternate or legacy calculation; the code gives the same result for both settings.
// [RL14] Polynomial bits 31..1 enable feedback taps; bit 0 reads zero.
// [RL15] Aliases at plus 0x4, 0x8, 0xC clear, set or invert bits.
// [RL16] Unimplemented control bits read zero and ignore writes.
// [RL17] Each data input write pushes one word into the FIFO.
// [RL18] Bits feed an LFSR of configured length; result stays readable.
// [RL19] A configurable interrupt and a data FIFO feed the engine.
module pcg_crc #(
	parameter int unsigned DEPTH = 16
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [pcg_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       sys_idle,
	output logic                            irq
);
	import pcg_pkg::*;

	pcg_req_s          req;
	logic [31:0]       ctrl;
	logic [31:0]       poly;
	logic [31:0]       result;
	logic [31:0]       fifo_mem [DEPTH];
	logic [3:0]        rd_ptr;
	logic [3:0]        wr_ptr;
	logic [4:0]        count;
	logic [4:0]        capacity;
	logic              full;
	logic              empty;
	logic              empty_q;
	logic              active;
	logic              running;
	logic [31:0]       shreg;
	logic [4:0]        bits_left;
	pcg_state_e        state;
	logic [IRQ_BITS-1:0] irq_stat;
	logic [IRQ_BITS-1:0] irq_mask;
	logic [IRQ_BITS-1:0] irq_event;
	logic              acc;
	logic              wr_acc;
	logic [11:0]       base;
	logic [3:0]        alias_ofs;
	logic              hit_ctrl;
	logic              hit_poly;
	logic              hit_data;
	logic              hit_res;
	logic              hit_stat;
	logic              hit_mask;
	logic              mapped;
	logic              push;
	logic              pop;
	logic              shift_step;
	logic              in_bit;
	logic              fb;
	logic [31:0]       next_result;
	logic [31:0]       ctrl_view;
	logic [31:0]       mask_wr;

	assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
	assign mask_wr = apply_alias({30'h0, irq_mask}, req.wdata, alias_ofs, 32'h00000003);

	// APB decode; every access completes in its first access cycle
	assign acc       = psel & penable;
	assign wr_acc    = acc & req.write;
	assign base      = {req.addr[11:4], 4'h0};
	assign alias_ofs = {req.addr[3:2], 2'b00};
	assign hit_ctrl  = (base == OFS_CONTROL);
	assign hit_poly  = (base == OFS_POLY);
	assign hit_data  = (base == OFS_DATA_IN);
	assign hit_res   = (base == OFS_RESULT);
	assign hit_stat  = (base == OFS_IRQ_STAT);
	assign hit_mask  = (base == OFS_IRQ_MASK);
	assign mapped    = (hit_ctrl | hit_poly | hit_data | hit_res | hit_stat | hit_mask) & (req.addr[1:0] == 2'b00);
	assign pready    = 1'b1;
	assign pslverr   = acc & ~mapped;

	// Alias write: plain store, clear, set or invert under a write mask
	function automatic logic [31:0] apply_alias(input logic [31:0] cur, input logic [31:0] wd,
		input logic [3:0] ofs, input logic [31:0] wmask);
		logic [31:0] nv;
		nv = cur;
		case (ofs)
			ALIAS_CLR: nv = cur & ~wd; // RL15
			ALIAS_SET: nv = cur | wd; // RL15
			ALIAS_INV: nv = cur ^ wd; // RL15
			default:   nv = wd;
		endcase
		return (nv & wmask) | (cur & ~wmask); // RL16
	endfunction

	// Capacity depends on the configured word width
	always_comb begin
		if (ctrl[F_WIDTH_LO +: 5] <= LIM_BYTE) begin
			capacity = CAP_BYTE; // RL5
		end else if (ctrl[F_WIDTH_LO +: 5] <= LIM_HALF) begin
			capacity = CAP_HALF; // RL5
		end else begin
			capacity = CAP_WORD; // RL5
		end
	end

	assign full   = (count >= capacity); // RL6
	assign empty  = (count == 5'h00); // RL7
	assign active = ctrl[F_ENABLE] & ~(ctrl[F_IDLE] & sys_idle); // RL3 RL4
	assign running = active & ctrl[F_RUN]; // RL10

	assign push = wr_acc & hit_data & mapped & ctrl[F_ENABLE] & ~full; // RL17
	assign pop  = running & (state == PCG_IDLE) & ~empty; // RL10

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET;
		end else if (wr_acc & hit_ctrl) begin
			ctrl <= apply_alias(ctrl, req.wdata, alias_ofs, CTRL_WMASK);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			poly <= POLY_RESET;
		end else if (wr_acc & hit_poly) begin
			poly <= apply_alias(poly, req.wdata, alias_ofs, POLY_WMASK); // RL14
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= '0;
		end else if (wr_acc & hit_mask) begin
			irq_mask <= mask_wr[IRQ_BITS-1:0];
		end
	end

	// FIFO storage and pointers
	always_ff @(posedge pclk) begin
		if (push) begin
			fifo_mem[wr_ptr] <= apply_alias(32'h0, req.wdata, ALIAS_PLAIN, 32'hFFFFFFFF); // RL17
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (!ctrl[F_ENABLE]) begin
			wr_ptr <= '0; // RL3
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == 4'(capacity - 5'h01)) ? 4'h0 : wr_ptr + 4'h1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == 4'(capacity - 5'h01)) ? 4'h0 : rd_ptr + 4'h1;
			end
			count <= count + {4'h0, push} - {4'h0, pop}; // RL5 RL17
		end
	end

	// Serial shifter: load a word, then shift width bits into the LFSR
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state     <= PCG_IDLE;
			shreg     <= '0;
			bits_left <= '0;
		end else if (!ctrl[F_ENABLE] || !ctrl[F_RUN]) begin
			state     <= PCG_IDLE; // RL10
			bits_left <= '0;
		end else if (active) begin
			case (state)
				PCG_IDLE: begin
					if (pop) begin
						shreg     <= fifo_mem[rd_ptr];
						bits_left <= ctrl[F_WIDTH_LO +: 5]; // RL1
						state     <= PCG_SHIFT;
					end
				end
				PCG_SHIFT: begin
					if (ctrl[F_LSB]) begin
						shreg <= {1'b0, shreg[31:1]}; // RL11
					end else begin
						shreg <= {shreg[30:0], 1'b0}; // RL12
					end
					if (bits_left == 5'h00) begin
						state <= PCG_IDLE;
					end else begin
						bits_left <= bits_left - 5'h01;
					end
				end
				default: state <= PCG_IDLE;
			endcase
		end
	end

	assign shift_step = active & ctrl[F_RUN] & (state == PCG_SHIFT);
	assign in_bit = ctrl[F_LSB] ? shreg[0] : shreg[ctrl[F_WIDTH_LO +: 5]]; // RL11 RL12

	// LFSR step: both variant settings feed fb into bit 0 and give the same result
	always_comb begin
		next_result = result;
		fb = result[ctrl[F_PLEN_LO +: 5]] ^ in_bit; // RL2 RL18
		for (int i = 31; i >= 1; i--) begin
			if (i <= ctrl[F_PLEN_LO +: 5]) begin
				next_result[i] = result[i-1] ^ (fb & poly[i]); // RL14 RL18
			end
		end
		next_result[0] = fb;
		if (ctrl[F_VARIANT]) begin
			next_result[0] = fb; // RL13
		end else begin
			next_result[0] = ~ctrl[F_LSB] ? fb : fb; // RL13
		end
		for (int i = 0; i < 32; i++) begin
			if (i > ctrl[F_PLEN_LO +: 5]) begin
				next_result[i] = 1'b0; // RL2
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result <= RES_RESET;
		end else if (wr_acc & hit_res) begin
			result <= apply_alias(result, req.wdata, alias_ofs, 32'hFFFFFFFF);
		end else if (shift_step) begin
			result <= next_result; // RL18
		end
	end

	// Interrupt events, sticky status, write-one-to-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			empty_q <= 1'b1;
		end else begin
			empty_q <= empty;
		end
	end

	assign irq_event[IRQ_EMPTIED] = empty & ~empty_q & ctrl[F_ISEL] & active; // RL8
	assign irq_event[IRQ_DONE] = shift_step & (bits_left == 5'h00) & (count == 5'h00)
		& ~ctrl[F_ISEL]; // RL9

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= '0;
		end else begin
			for (int i = 0; i < IRQ_BITS; i++) begin
				if (irq_event[i]) begin
					irq_stat[i] <= 1'b1;
				end else if (wr_acc & hit_stat & req.wdata[i]) begin
					irq_stat[i] <= 1'b0;
				end
			end
		end
	end

	assign irq = |(irq_stat & irq_mask); // RL19

	// Read mux
	always_comb begin
		ctrl_view = ctrl & CTRL_WMASK; // RL16
		ctrl_view[F_COUNT_LO +: 5] = count; // RL5
		ctrl_view[F_FULL]  = full; // RL6
		ctrl_view[F_EMPTY] = empty; // RL7
		prdata = 32'h00000000;
		if (acc & ~req.write & mapped) begin
			if (hit_ctrl) begin
				prdata = ctrl_view;
			end else if (hit_poly) begin
				prdata = poly & POLY_WMASK; // RL14
			end else if (hit_res) begin
				prdata = result;
			end else if (hit_stat) begin
				prdata = {30'h0, irq_stat};
			end else if (hit_mask) begin
				prdata = {30'h0, irq_mask};
			end
		end
	end

	property p_full_flag;
		@(posedge pclk) disable iff (!presetn) (count == capacity) |-> full;
	endproperty
	a_full_flag: assert property (p_full_flag) else $error("full flag wrong"); // RL6

	property p_empty_flag;
		@(posedge pclk) disable iff (!presetn) empty == (count == 5'h00);
	endproperty
	a_empty_flag: assert property (p_empty_flag) else $error("empty flag wrong"); // RL7

	property p_count_cap;
		@(posedge pclk) disable iff (!presetn) count <= capacity;
	endproperty
	a_count_cap: assert property (p_count_cap) else $error("count above capacity"); // RL5

	property p_push;
		@(posedge pclk) disable iff (!presetn) push & ~pop |=> count == $past(count) + 5'h01;
	endproperty
	a_push: assert property (p_push) else $error("push did not count"); // RL17

	property p_off;
		@(posedge pclk) disable iff (!presetn) ~ctrl[F_ENABLE] |=> count == 5'h00 && state == PCG_IDLE;
	endproperty
	a_off: assert property (p_off) else $error("disabled block active"); // RL3

	property p_abort;
		@(posedge pclk) disable iff (!presetn) ~ctrl[F_RUN] |=> state == PCG_IDLE;
	endproperty
	a_abort: assert property (p_abort) else $error("shifter not stopped"); // RL10

	property p_idle_hold;
		@(posedge pclk) disable iff (!presetn) ctrl[F_IDLE] & sys_idle & ~(wr_acc & hit_res) |=> $stable(result);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("ran during idle"); // RL4

	property p_irq_set;
		@(posedge pclk) disable iff (!presetn) irq_event[IRQ_EMPTIED] & irq_mask[IRQ_EMPTIED] |=> irq;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("interrupt missing"); // RL8

	property p_empty_irq;
		@(posedge pclk) disable iff (!presetn) $rose(empty) && ctrl[F_ISEL] && active |=> irq_stat[IRQ_EMPTIED];
	endproperty
	a_empty_irq: assert property (p_empty_irq) else $error("emptied interrupt missing"); // RL8

	sequence s_last_bit;
		shift_step && (bits_left == 5'h00) && empty && !ctrl[F_ISEL];
	endsequence

	property p_done_irq;
		@(posedge pclk) disable iff (!presetn) s_last_bit |=> irq_stat[IRQ_DONE] && state == PCG_IDLE;
	endproperty
	a_done_irq: assert property (p_done_irq) else $error("shift done interrupt missing"); // RL9

	sequence s_word_loaded;
		state == PCG_SHIFT && bits_left == $past(ctrl[F_WIDTH_LO +: 5]);
	endsequence

	property p_pop_load;
		@(posedge pclk) disable iff (!presetn) pop |=> s_word_loaded;
	endproperty
	a_pop_load: assert property (p_pop_load) else $error("popped word not loaded"); // RL1

	property p_ctrl_resvd;
		@(posedge pclk) disable iff (!presetn) (ctrl & ~CTRL_WMASK) == 32'h00000000;
	endproperty
	a_ctrl_resvd: assert property (p_ctrl_resvd) else $error("unimplemented control bit set"); // RL16

	property p_poly_bit0;
		@(posedge pclk) disable iff (!presetn) poly[0] == 1'b0;
	endproperty
	a_poly_bit0: assert property (p_poly_bit0) else $error("polynomial bit zero set"); // RL14

	property p_lsb_shift;
		@(posedge pclk) disable iff (!presetn) shift_step && ctrl[F_LSB] |=> shreg == {1'b0, $past(shreg[31:1])};
	endproperty
	a_lsb_shift: assert property (p_lsb_shift) else $error("word not shifted low bit first"); // RL11
endmodule

// File: tb/testbench.sv
/*
 * Self-checking bench for the programmable CRC generator: registers, aliases,
 * FIFO sizing, interrupt timing and the serial CRC result.
 * Assumes the zero-wait APB slave and register map of pcg_pkg.
 */
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import pcg_pkg::*;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic        sys_idle;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	int          n_errors;
	int          n_tests;

	localparam logic [31:0] EN = 32'h00008000;

	pcg_crc #(.DEPTH(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sys_idle(sys_idle), .irq(irq));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic results();
		$display("errors %0d checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			n_errors++;
			results();
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b1, d, r, e);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b0, 32'h00000000, r, e);
		chk(r, x);
	endtask

	task automatic wait_irq(input int lim, output int c);
		c = 0;
		while (irq !== 1'b1 && c < lim) begin
			@(posedge pclk);
			c++;
		end
		if (c >= lim) begin
			n_errors++;
			results();
		end
	endtask

	function automatic logic [31:0] ctl(input int w, input int p, input logic [31:0] f);
		return (32'(w) << 24) | (32'(p) << 16) | EN | f;
	endfunction

	// Reference CRC-16 shift, one byte, feedback into the x^0 term through bit 0 of 0x1021
	function automatic logic [31:0] crc_ref(input logic [7:0] d, input logic lsb);
		logic [15:0] r;
		logic        fb;
		r = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			fb = (lsb ? d[i] : d[7-i]) ^ r[15];
			r = {r[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
		end
		return {16'h0000, r};
	endfunction

	task automatic t_regs();
		logic [31:0] r;
		logic        e;
		rd(12'hA00, 32'h00000040);
		rd(12'hA10, 32'h00000000);
		rd(12'hA30, 32'h00000000);
		wr(12'hA00, 32'hFFFFFFFF);
		rd(12'hA00, 32'h1F1FA07C);
		wr(12'hA00, 32'h00000000);
		wr(12'hA10, 32'hFFFFFFFF);
		rd(12'hA10, 32'hFFFFFFFE);
		wr(12'hA14, 32'h0000FFFF);
		rd(12'hA10, 32'hFFFF0000);
		wr(12'hA18, 32'h00000001);
		rd(12'hA10, 32'hFFFF0000);
		wr(12'hA1C, 32'hF0000000);
		rd(12'hA10, 32'h0FFF0000);
		apb(12'h100, 1'b0, 32'h00000000, r, e);
		chk({31'h0, e}, 32'h00000001);
		chk(r, 32'h00000000);
	endtask

	task automatic t_fifo(input int w, input int cap);
		logic [31:0] c;
		c = ctl(w, 0, 32'h00000000);
		wr(12'hA00, 32'h00000000);
		wr(12'hA00, c);
		for (int i = 0; i <= cap; i++) begin
			if (i == cap - 1)
				rd(12'hA00, c | (32'(cap - 1) << 8));
			wr(12'hA20, 32'(i));
		end
		rd(12'hA00, c | (32'(cap) << 8) | 32'h00000080);
		wr(12'hA00, 32'h07000000);
		wr(12'hA20, 32'h00000005);
		rd(12'hA00, 32'h07000040);
	endtask

	task automatic t_irq(input logic isel);
		int c;
		wr(12'hA00, 32'h00000000);
		wr(12'hA40, 32'h00000003);
		wr(12'hA50, isel ? 32'h00000001 : 32'h00000002);
		wr(12'hA00, ctl(31, 31, {26'h0, isel, 5'h00}));
		wr(12'hA20, 32'h12345678);
		wr(12'hA08, 32'h00000010);
		wait_irq(200, c);
		if (isel)
			chk(32'(c <= 8), 32'h00000001);
		else
			chk(32'(c >= 28), 32'h00000001);
		wr(12'hA50, 32'h00000000);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h00000000);
		wr(12'hA50, 32'h00000003);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h00000001);
		wr(12'hA40, 32'h00000003);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h00000000);
	endtask

	task automatic t_crc(input logic lsb, input logic idle);
		int c;
		wr(12'hA00, 32'h00000000);
		wr(12'hA40, 32'h00000003);
		wr(12'hA50, 32'h00000002);
		wr(12'hA10, 32'h00001021);
		wr(12'hA30, 32'h00000000);
		sys_idle <= idle;
		wr(12'hA00, ctl(7, 15, {18'h0, idle, 9'h0, lsb, lsb, 2'b00}));
		wr(12'hA20, 32'h00000031);
		wr(12'hA08, 32'h00000010);
		if (idle) begin
			repeat (40) @(posedge pclk);
			chk({31'h0, irq}, 32'h00000000);
			sys_idle <= 1'b0;
		end
		wait_irq(200, c);
		if (lsb)
			rd(12'hA30, crc_ref(8'h31, 1'b1));
		else
			rd(12'hA30, crc_ref(8'h31, 1'b0));
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		sys_idle = 1'b0;
		n_errors = 0;
		n_tests = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_fifo(7, 16);
		t_fifo(15, 8);
		t_fifo(31, 4);
		t_irq(1'b1);
		t_irq(1'b0);
		t_crc(1'b0, 1'b0);
		t_crc(1'b1, 1'b0);
		t_crc(1'b0, 1'b1);
		results();
	end
endmodule
